// file: pbda_pkg.sv
// Constants and types for the packet buffer diagnostic access block.
// Assumes a 17-bit AXI4-Lite byte address space with 32-bit data.
`default_nettype none

package pbda_pkg;

   // Register byte offsets
   localparam logic [16:0] RX_TAIL_OFS = 17'h02418;
   localparam logic [16:0] RX_TAIL_SAVED_OFS = 17'h02428;
   localparam logic [16:0] RX_COUNT_OFS = 17'h02430;
   localparam logic [16:0] TX_HEAD_OFS = 17'h03410;
   localparam logic [16:0] TX_TAIL_OFS = 17'h03418;
   localparam logic [16:0] TX_HEAD_SAVED_OFS = 17'h03420;
   localparam logic [16:0] TX_TAIL_SAVED_OFS = 17'h03428;
   localparam logic [16:0] TX_COUNT_OFS = 17'h03430;
   localparam logic [16:0] SPLIT_OFS = 17'h03440;
   localparam logic [16:0] WINDOW_BASE = 17'h10000;
   localparam logic [16:0] WINDOW_LAST = 17'h1FFFC;

   // Field widths
   localparam int PTR_W = 13;
   localparam int TX_PTR_W = 11;
   localparam int KB_W = 7;
   localparam int MEM_WORDS = 8192;

   // Buffer sizes in KB and the split after reset
   localparam logic [6:0] FULL_KB = 7'h40;
   localparam logic [6:0] FULL_RX_KB = 7'h30;
   localparam logic [6:0] SMALL_KB = 7'h28;
   localparam logic [6:0] SMALL_RX_KB = 7'h16;

   // Values after reset
   localparam logic [12:0] PTR_RESET = 13'h0000;
   localparam logic [10:0] TX_PTR_RESET = 11'h000;
   localparam logic [12:0] COUNT_RESET = 13'h0000;

   // Longest transmit pointer span in 64-bit words
   localparam logic [13:0] TX_PTR_SPAN = 14'h0800;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Datapath operations from the controller
   typedef enum logic [1:0] {
      PBDA_OP_RX_WR,
      PBDA_OP_RX_RD,
      PBDA_OP_TX_WR,
      PBDA_OP_TX_RD
   } pbda_op_t;

   // Read channel phases
   typedef enum logic [1:0] {
      PBDA_RD_IDLE,
      PBDA_RD_FETCH,
      PBDA_RD_LOAD,
      PBDA_RD_SHOW
   } pbda_rd_t;

endpackage : pbda_pkg

`default_nettype wire

// file: pbda_mem.sv
// Dual-port packet buffer memory, 8192 words of 64 bits.
// Port A has byte enables for 32-bit diagnostic access; port B serves the datapath.
`timescale 1ns/1ns
`default_nettype none

module pbda_mem (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [12:0] a_addr,
   input wire logic a_we,
   input wire logic [7:0] a_be,
   input wire logic [63:0] a_wdata,
   output logic [63:0] a_q,
   input wire logic [12:0] b_addr,
   input wire logic b_we,
   input wire logic b_re,
   input wire logic [63:0] b_wdata,
   output logic [63:0] b_q
);

   // Contents are not cleared by reset; only the read registers are
   logic [63:0] mem [pbda_pkg::MEM_WORDS];

   always_ff @(posedge aclk) begin
      for (int i = 0; i < 8; i++) begin
         if (a_we && a_be[i]) begin
            mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
         end
      end
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_q <= 64'h0000000000000000;
         b_q <= 64'h0000000000000000;
      end else begin
         a_q <= mem[a_addr];
         // Datapath read data must stand until the next read op
         if (b_re) begin
            b_q <= mem[b_addr];
         end
      end
   end

endmodule : pbda_mem

`default_nettype wire

// file: pbda_core.sv
// Packet buffer diagnostic access: AXI4-Lite register slave, FIFO pointers and counts,
// and the memory-mapped window onto the shared packet buffer.
// Assumes the controller datapath runs on aclk and issues at most one buffer
// operation per cycle; software touches these registers only for diagnostics.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module pbda_core #(
   parameter bit REDUCED = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [16:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [16:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Controller datapath
   input wire logic dp_valid,
   input wire pbda_pkg::pbda_op_t dp_op,
   input wire logic [63:0] dp_wdata,
   input wire logic dp_last,
   output logic [63:0] dp_rdata,
   output logic dp_rvalid
);

   localparam logic [6:0] TOTAL_KB = REDUCED ? pbda_pkg::SMALL_KB : pbda_pkg::FULL_KB;
   localparam logic [6:0] RX_KB_RESET = REDUCED ? pbda_pkg::SMALL_RX_KB
                                                : pbda_pkg::FULL_RX_KB;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [16:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      pbda_pkg::pbda_rd_t rd_state;
      logic arready;
      logic [16:0] raddr;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [12:0] rx_tail;
      logic [12:0] rx_head;
      logic [12:0] rx_tail_saved;
      logic [12:0] rx_count;
      logic [10:0] tx_head;
      logic [10:0] tx_tail;
      logic [12:0] tx_head_saved;
      logic [12:0] tx_tail_saved;
      logic [12:0] tx_count;
      logic [6:0] rx_kb;
      logic dp_rvalid;
   } pbda_state_t;

   localparam pbda_state_t RESET_STATE = '{
      awready: 1'b1,
      wready: 1'b1,
      aw_held: 1'b0,
      w_held: 1'b0,
      waddr: 17'h00000,
      wdata: 32'h00000000,
      wstrb: 4'h0,
      bvalid: 1'b0,
      bresp: pbda_pkg::RESP_OKAY,
      rd_state: pbda_pkg::PBDA_RD_IDLE,
      arready: 1'b1,
      raddr: 17'h00000,
      rvalid: 1'b0,
      rresp: pbda_pkg::RESP_OKAY,
      rdata: 32'h00000000,
      rx_tail: pbda_pkg::PTR_RESET,
      rx_head: pbda_pkg::PTR_RESET,
      rx_tail_saved: pbda_pkg::PTR_RESET,
      rx_count: pbda_pkg::COUNT_RESET,
      tx_head: pbda_pkg::TX_PTR_RESET,
      tx_tail: pbda_pkg::TX_PTR_RESET,
      tx_head_saved: pbda_pkg::PTR_RESET,
      tx_tail_saved: pbda_pkg::PTR_RESET,
      tx_count: pbda_pkg::COUNT_RESET,
      rx_kb: RX_KB_RESET,
      dp_rvalid: 1'b0
   };

   pbda_state_t s;
   pbda_state_t next_s;

   // KB to 64-bit words: 128 words per KB
   function automatic logic [13:0] pbda_kb_words(input logic [6:0] kb);
      return {kb, 7'h00};
   endfunction : pbda_kb_words

   // One word step with wrap to the region start
   function automatic logic [12:0] pbda_step(input logic [12:0] ptr, input logic [13:0] limit);
      logic [13:0] inc;
      inc = {1'b0, ptr} + 14'h0001;
      return (inc >= limit) ? 13'h0000 : inc[12:0];
   endfunction : pbda_step

   // Byte-lane merge of a write into a 32-bit register image
   function automatic logic [31:0] pbda_merge(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return res;
   endfunction : pbda_merge

   // Window hit: inside 10000h..1FFFCh and below the built buffer size
   function automatic logic pbda_in_window(input logic [16:0] addr);
      return (addr >= pbda_pkg::WINDOW_BASE) && (addr <= pbda_pkg::WINDOW_LAST)
             && ({1'b0, addr[15:3]} < pbda_kb_words(TOTAL_KB));
   endfunction : pbda_in_window

   // Register image as software sees it; unused upper bits are zero
   function automatic logic [31:0] pbda_reg_value(input logic [16:0] addr,
                                                  input pbda_state_t st);
      logic [31:0] v;
      v = 32'h00000000;
      if (addr == pbda_pkg::RX_TAIL_OFS) begin
         v = {19'h00000, st.rx_tail};
      end else if (addr == pbda_pkg::RX_TAIL_SAVED_OFS) begin
         v = {19'h00000, st.rx_tail_saved};
      end else if (addr == pbda_pkg::RX_COUNT_OFS) begin
         v = {19'h00000, st.rx_count};
      end else if (addr == pbda_pkg::TX_HEAD_OFS) begin
         v = {21'h000000, st.tx_head};
      end else if (addr == pbda_pkg::TX_TAIL_OFS) begin
         v = {21'h000000, st.tx_tail};
      end else if (addr == pbda_pkg::TX_HEAD_SAVED_OFS) begin
         v = {19'h00000, st.tx_head_saved};
      end else if (addr == pbda_pkg::TX_TAIL_SAVED_OFS) begin
         v = {19'h00000, st.tx_tail_saved};
      end else if (addr == pbda_pkg::TX_COUNT_OFS) begin
         v = {19'h00000, st.tx_count};
      end else if (addr == pbda_pkg::SPLIT_OFS) begin
         v = {25'h0000000, st.rx_kb};
      end
      return v;
   endfunction : pbda_reg_value

   function automatic logic pbda_reg_hit(input logic [16:0] addr);
      return (addr == pbda_pkg::RX_TAIL_OFS) || (addr == pbda_pkg::RX_TAIL_SAVED_OFS)
             || (addr == pbda_pkg::RX_COUNT_OFS) || (addr == pbda_pkg::TX_HEAD_OFS)
             || (addr == pbda_pkg::TX_TAIL_OFS) || (addr == pbda_pkg::TX_HEAD_SAVED_OFS)
             || (addr == pbda_pkg::TX_TAIL_SAVED_OFS) || (addr == pbda_pkg::TX_COUNT_OFS)
             || (addr == pbda_pkg::SPLIT_OFS);
   endfunction : pbda_reg_hit

   // Region geometry from the current split
   logic [13:0] rx_words;
   logic [13:0] tx_words;
   logic [13:0] tx_limit;
   logic [12:0] tx_base;
   logic write_fire;
   logic [31:0] merged;
   logic [63:0] a_q;
   logic [12:0] a_addr;
   logic a_we;
   logic [7:0] a_be;
   logic [12:0] b_addr;
   logic b_we;
   logic b_re;

   always_comb begin
      rx_words = pbda_kb_words(s.rx_kb);
      tx_words = pbda_kb_words(TOTAL_KB) - rx_words;
      // Transmit pointers are only 11 bits wide, so a larger region wraps early
      tx_limit = (tx_words > pbda_pkg::TX_PTR_SPAN) ? pbda_pkg::TX_PTR_SPAN : tx_words;
      tx_base = rx_words[12:0];
   end

   // Writes wait while a read holds port A for its fetch
   assign write_fire = s.aw_held && s.w_held && !s.bvalid
                       && (s.rd_state != pbda_pkg::PBDA_RD_FETCH);
   assign merged = pbda_merge(pbda_reg_value(s.waddr, s), s.wdata, s.wstrb);

   // Port A: diagnostic window, 32-bit lanes inside a 64-bit word
   always_comb begin
      a_we = write_fire && pbda_in_window(s.waddr);
      a_addr = write_fire ? s.waddr[15:3] : s.raddr[15:3];
      a_be = s.waddr[2] ? {s.wstrb, 4'h0} : {4'h0, s.wstrb};
   end

   // Port B: datapath; transmit words sit above the receive region
   always_comb begin
      b_we = dp_valid && ((dp_op == pbda_pkg::PBDA_OP_RX_WR)
                          || (dp_op == pbda_pkg::PBDA_OP_TX_WR));
      b_re = dp_valid && !b_we;
      case (dp_op)
         pbda_pkg::PBDA_OP_RX_WR: b_addr = s.rx_tail;
         pbda_pkg::PBDA_OP_RX_RD: b_addr = s.rx_head;
         pbda_pkg::PBDA_OP_TX_WR: b_addr = 13'(tx_base + {2'b00, s.tx_tail});
         default: b_addr = 13'(tx_base + {2'b00, s.tx_head});
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.dp_rvalid = 1'b0;

      // Datapath advances pointers and counts
      if (dp_valid) begin
         case (dp_op)
            pbda_pkg::PBDA_OP_RX_WR: begin
               next_s.rx_tail = pbda_step(s.rx_tail, rx_words);
               if (dp_last) begin
                  next_s.rx_count = 13'(s.rx_count + 13'h0001);
               end
            end
            pbda_pkg::PBDA_OP_RX_RD: begin
               next_s.rx_head = pbda_step(s.rx_head, rx_words);
               next_s.dp_rvalid = 1'b1;
               if (dp_last) begin
                  next_s.rx_count = 13'(s.rx_count - 13'h0001);
               end
            end
            pbda_pkg::PBDA_OP_TX_WR: begin
               next_s.tx_tail = 11'(pbda_step({2'b00, s.tx_tail}, tx_limit));
               if (dp_last) begin
                  next_s.tx_count = 13'(s.tx_count + 13'h0001);
               end
            end
            default: begin
               next_s.tx_head = 11'(pbda_step({2'b00, s.tx_head}, tx_limit));
               next_s.dp_rvalid = 1'b1;
               if (dp_last) begin
                  next_s.tx_count = 13'(s.tx_count - 13'h0001);
               end
            end
         endcase
      end

      // Write address and data channels, taken in either order
      if (awvalid && s.awready) begin
         next_s.waddr = awaddr;
         next_s.aw_held = 1'b1;
         next_s.awready = 1'b0;
      end
      if (wvalid && s.wready) begin
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
         next_s.w_held = 1'b1;
         next_s.wready = 1'b0;
      end

      // Software write lands after the datapath update so it wins the cycle
      if (write_fire) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = pbda_pkg::RESP_OKAY;
         if (s.waddr == pbda_pkg::RX_TAIL_OFS) begin
            next_s.rx_tail = merged[12:0];
         end else if (s.waddr == pbda_pkg::RX_TAIL_SAVED_OFS) begin
            next_s.rx_tail_saved = merged[12:0];
         end else if (s.waddr == pbda_pkg::RX_COUNT_OFS) begin
            next_s.rx_count = merged[12:0];
         end else if (s.waddr == pbda_pkg::TX_HEAD_OFS) begin
            next_s.tx_head = merged[10:0];
         end else if (s.waddr == pbda_pkg::TX_TAIL_OFS) begin
            next_s.tx_tail = merged[10:0];
         end else if (s.waddr == pbda_pkg::TX_HEAD_SAVED_OFS) begin
            next_s.tx_head_saved = merged[12:0];
         end else if (s.waddr == pbda_pkg::TX_TAIL_SAVED_OFS) begin
            next_s.tx_tail_saved = merged[12:0];
         end else if (s.waddr == pbda_pkg::TX_COUNT_OFS) begin
            next_s.tx_count = merged[12:0];
         end else if (s.waddr == pbda_pkg::SPLIT_OFS) begin
            // Splits leaving either FIFO empty are ignored
            if ((merged[6:0] != 7'h00) && (merged[6:0] < TOTAL_KB)) begin
               next_s.rx_kb = merged[6:0];
            end
         end else if (!pbda_in_window(s.waddr)) begin
            next_s.bresp = pbda_pkg::RESP_DECERR;
         end
      end

      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Read channel: fetch, load memory output, then present
      case (s.rd_state)
         pbda_pkg::PBDA_RD_IDLE: begin
            if (arvalid && s.arready) begin
               next_s.raddr = araddr;
               next_s.arready = 1'b0;
               next_s.rd_state = pbda_pkg::PBDA_RD_FETCH;
            end
         end
         pbda_pkg::PBDA_RD_FETCH: begin
            next_s.rd_state = pbda_pkg::PBDA_RD_LOAD;
         end
         pbda_pkg::PBDA_RD_LOAD: begin
            next_s.rvalid = 1'b1;
            next_s.rd_state = pbda_pkg::PBDA_RD_SHOW;
            if (pbda_in_window(s.raddr)) begin
               next_s.rdata = s.raddr[2] ? a_q[63:32] : a_q[31:0];
               next_s.rresp = pbda_pkg::RESP_OKAY;
            end else if (pbda_reg_hit(s.raddr)) begin
               next_s.rdata = pbda_reg_value(s.raddr, s);
               next_s.rresp = pbda_pkg::RESP_OKAY;
            end else begin
               next_s.rdata = 32'h00000000;
               next_s.rresp = pbda_pkg::RESP_DECERR;
            end
         end
         default: begin
            if (rready) begin
               next_s.rvalid = 1'b0;
               next_s.arready = 1'b1;
               next_s.rd_state = pbda_pkg::PBDA_RD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   pbda_mem u_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .a_addr(a_addr),
      .a_we(a_we),
      .a_be(a_be),
      .a_wdata({s.wdata, s.wdata}),
      .a_q(a_q),
      .b_addr(b_addr),
      .b_we(b_we),
      .b_re(b_re),
      .b_wdata(dp_wdata),
      .b_q(dp_rdata)
   );

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign dp_rvalid = s.dp_rvalid;

endmodule : pbda_core

`default_nettype wire

// file: pbda_core_sva.sv
// Concurrent checks on the register bus and datapath ports of pbda_core.
// Assumes one clock domain, aclk, with aresetn as a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module pbda_core_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [16:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic dp_valid,
   input wire pbda_pkg::pbda_op_t dp_op,
   input wire logic [63:0] dp_rdata,
   input wire logic dp_rvalid
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_reset_idle: assert property ($rose(aresetn) |->
      awready && wready && arready && !bvalid && !rvalid && !dp_rvalid)
      else $error("bus not idle after reset");
   chk_read_delay: assert property (arvalid && arready |=> !rvalid [*2] ##1 rvalid)
      else $error("read answer not in third cycle");
   // Register reads never expose bits above the 13-bit fields
   chk_reg_upper: assert property (arvalid && arready && araddr < pbda_pkg::WINDOW_BASE
      |-> ##3 rvalid && rdata[31:13] == 19'h00000)
      else $error("register read has upper bits set");
   chk_write_delay: assert property (awvalid && awready && wvalid && wready
      |-> ##[2:3] bvalid)
      else $error("write answer late");
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   chk_rvalid_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped early");
   chk_one_read: assert property (rvalid |-> !arready)
      else $error("second read accepted");
   chk_dp_answer: assert property (dp_valid && dp_op[0] |=> dp_rvalid)
      else $error("datapath read not answered");
   chk_dp_cause: assert property (dp_rvalid |-> $past(dp_valid) && $past(dp_op[0]))
      else $error("datapath answer without read");
   chk_dp_hold: assert property (!(dp_valid && dp_op[0]) |=> $stable(dp_rdata))
      else $error("datapath data changed without read");

   cov_write: cover property (bvalid && bready);
   cov_read: cover property (rvalid && rready);
   cov_dp_read: cover property (dp_rvalid);
endmodule : pbda_core_sva

bind pbda_core pbda_core_sva chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready), .dp_valid(dp_valid), .dp_op(dp_op),
   .dp_rdata(dp_rdata), .dp_rvalid(dp_rvalid));

`default_nettype wire

// file: pbda_core_tb.sv
// Self-checking bench for pbda_core: register and window traffic plus datapath operations.
// Drives every input at rising edges; the design runs with the full 64 KB buffer.
`timescale 1ns/1ns
`default_nettype none
`define chk_eq(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module pbda_core_tb;
   localparam logic [1:0] OK = pbda_pkg::RESP_OKAY;
   localparam logic [16:0] OFS [8] = '{pbda_pkg::RX_TAIL_OFS, pbda_pkg::RX_TAIL_SAVED_OFS,
      pbda_pkg::RX_COUNT_OFS, pbda_pkg::TX_HEAD_OFS, pbda_pkg::TX_TAIL_OFS,
      pbda_pkg::TX_HEAD_SAVED_OFS, pbda_pkg::TX_TAIL_SAVED_OFS, pbda_pkg::TX_COUNT_OFS};
   localparam logic [31:0] MSK [8] = '{32'h00001FFF, 32'h00001FFF, 32'h00001FFF,
      32'h000007FF, 32'h000007FF, 32'h00001FFF, 32'h00001FFF, 32'h00001FFF};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [16:0] awaddr = 17'h00000, araddr = 17'h00000;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic dp_valid = 1'h0, dp_last = 1'h0;
   pbda_pkg::pbda_op_t dp_op = pbda_pkg::PBDA_OP_RX_WR;
   logic [63:0] dp_wdata = 64'h0;
   logic awready, wready, bvalid, arready, rvalid, dp_rvalid, v;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [63:0] dp_rdata, q;
   int num_errors = 0;
   int compares = 0;

   always #20 aclk = ~aclk;

   pbda_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .dp_valid(dp_valid), .dp_op(dp_op), .dp_wdata(dp_wdata), .dp_last(dp_last),
      .dp_rdata(dp_rdata), .dp_rvalid(dp_rvalid));

   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic hang;
      num_errors++;
      $display("ERROR %0t: no answer", $time);
      tally_and_finish();
   endtask : hang

   // Address and data go out together; each is dropped at its own ready
   // Called only while the datapath is idle
   task automatic wr(input logic [16:0] a, input logic [31:0] dd,
                     input logic [1:0] er = pbda_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (++n > 40) hang();
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
      `chk_eq(r, er)
   endtask : wr

   task automatic rd_chk(input logic [16:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (++n > 40) hang();
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      `chk_eq(d, e)
      `chk_eq(r, er)
   endtask : rd_chk

   // One operation; the answer is sampled in the cycle after it is taken
   task automatic dp(input pbda_pkg::pbda_op_t op, input logic [63:0] wd, input logic last);
      @(posedge aclk);
      dp_valid <= 1'h1;
      dp_op <= op;
      dp_wdata <= wd;
      dp_last <= last;
      @(posedge aclk);
      dp_valid <= 1'h0;
      @(posedge aclk);
      q = dp_rdata;
      v = dp_rvalid;
   endtask : dp

   task automatic t_reset;
      for (int i = 0; i < 8; i++) begin
         rd_chk(OFS[i], 32'h00000000, OK);
      end
      rd_chk(pbda_pkg::SPLIT_OFS, 32'h00000030, OK);
      rd_chk(17'h0FFFC, 32'h00000000, pbda_pkg::RESP_DECERR);
      wr(17'h0FFF8, 32'h00000001, pbda_pkg::RESP_DECERR);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         wr(OFS[i], 32'hFFFFFFFF);
         rd_chk(OFS[i], MSK[i], OK);
         wr(OFS[i], 32'h00000000);
      end
      $display("t_regs done");
   endtask : t_regs

   task automatic t_window;
      wr(17'h10000, 32'h11223344);
      wr(17'h10004, 32'h55667788);
      wr(pbda_pkg::WINDOW_LAST, 32'hA5A5A5A5);
      rd_chk(pbda_pkg::WINDOW_LAST, 32'hA5A5A5A5, OK);
      rd_chk(17'h10004, 32'h55667788, OK);
      dp(pbda_pkg::PBDA_OP_RX_RD, 64'h0, 1'h0);
      `chk_eq({v, q}, {1'h1, 64'h5566778811223344})
      $display("t_window done");
   endtask : t_window

   task automatic t_datapath;
      dp(pbda_pkg::PBDA_OP_RX_WR, 64'h0123456789ABCDEF, 1'h1);
      rd_chk(pbda_pkg::RX_TAIL_OFS, 32'h00000001, OK);
      rd_chk(pbda_pkg::RX_COUNT_OFS, 32'h00000001, OK);
      rd_chk(17'h10000, 32'h89ABCDEF, OK);
      dp(pbda_pkg::PBDA_OP_TX_WR, 64'hFEDCBA9876543210, 1'h1);
      rd_chk(17'h1C004, 32'hFEDCBA98, OK);
      rd_chk(pbda_pkg::TX_TAIL_OFS, 32'h00000001, OK);
      rd_chk(pbda_pkg::TX_COUNT_OFS, 32'h00000001, OK);
      dp(pbda_pkg::PBDA_OP_TX_RD, 64'h0, 1'h1);
      `chk_eq(q, 64'hFEDCBA9876543210)
      rd_chk(pbda_pkg::TX_HEAD_OFS, 32'h00000001, OK);
      rd_chk(pbda_pkg::TX_COUNT_OFS, 32'h00000000, OK);
      $display("t_datapath done");
   endtask : t_datapath

   task automatic t_split;
      wr(pbda_pkg::RX_TAIL_OFS, 32'h000017FF);
      dp(pbda_pkg::PBDA_OP_RX_WR, 64'h1, 1'h0);
      rd_chk(pbda_pkg::RX_TAIL_OFS, 32'h00000000, OK);
      wr(pbda_pkg::TX_TAIL_OFS, 32'h000007FF);
      dp(pbda_pkg::PBDA_OP_TX_WR, 64'h2, 1'h0);
      rd_chk(pbda_pkg::TX_TAIL_OFS, 32'h00000000, OK);
      wr(pbda_pkg::SPLIT_OFS, 32'h00000020);
      wr(pbda_pkg::SPLIT_OFS, 32'h00000000);
      rd_chk(pbda_pkg::SPLIT_OFS, 32'h00000020, OK);
      wr(pbda_pkg::RX_TAIL_OFS, 32'h00000FFF);
      dp(pbda_pkg::PBDA_OP_RX_WR, 64'h3, 1'h0);
      rd_chk(pbda_pkg::RX_TAIL_OFS, 32'h00000000, OK);
      dp(pbda_pkg::PBDA_OP_TX_WR, 64'h4, 1'h0);
      rd_chk(17'h18000, 32'h00000004, OK);
      $display("t_split done");
   endtask : t_split

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_window();
      t_datapath();
      t_split();
      tally_and_finish();
   end
endmodule : pbda_core_tb

`default_nettype wire
